// >>> rtl/smsc_manager.sv
// smsc_manager: one socket manager with apb register access
// assumes the fetch path grants one manager at a time and holds grant
// until done; trigger and removal grant inputs are asynchronous pins
// Function
// RULE1: two states; reset state chosen at build
// RULE2: load error shuts down unless disabled
// RULE3: active idles until trigger, then removes
// RULE4: four removal modes per module
// RULE5: removal request held until grant
// RULE6: module holds grant until removed
// RULE7: software removal: interrupt, request until Proceed
// RULE8: software-only modules tie grant high
// RULE9: isolate after removal until load succeeds
// RULE10: clearing mode loads clearing image first
// RULE11: request fetch path, then fetch image
// RULE12: clearing mode uses second separate request
// RULE13: software bring-up interrupt after load
// RULE14: module reset configurable level and length
// RULE15: isolation released entering module reset
// RULE16: after bring-up return to trigger watching
// RULE17: shut down ignores triggers, no load
// RULE18: Shutdown command enters shut down
// RULE19: restart without status keeps occupancy
// RULE20: restart with status takes supplied occupancy
// RULE21: User Control drives outputs when shut down
// RULE22: live grant visible on status
// RULE23: rising trigger edge activates, never cancelled
// RULE24: reset held three cycles minimum
// RULE25: fetch grant held until transfer completes
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module smsc_manager #(
  parameter bit START_SHUT = 1'b0,
  parameter bit ERR_SHUTDOWN = 1'b1,
  parameter bit CLEARING = 1'b0,
  parameter bit RESET_LEVEL = 1'b1,
  parameter bit START_FULL = 1'b0
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [smsc_pkg::NTRIG-1:0] HARDWARE_TRIGGER_INPUTS,
  input wire logic MODULE_REMOVAL_GRANT,
  output logic MODULE_REMOVAL_REQUEST,
  output logic SOCKET_ISOLATE,
  output logic MODULE_RESET_OUT,
  output logic SOFTWARE_REMOVAL_REQUEST,
  output logic SOFTWARE_BRINGUP_REQUEST,
  output logic SOFTWARE_EVENT,
  output logic FETCH_REQ,
  input wire logic FETCH_GRANT,
  output logic FETCH_START,
  output logic FETCH_CLEARING,
  output logic [smsc_pkg::MODW-1:0] FETCH_MODULE,
  input wire logic FETCH_DONE,
  input wire logic FETCH_ERROR,
  output logic [31:0] STATUS_STREAM
);

  smsc_pkg::smsc_regs_t r;
  smsc_pkg::smsc_regs_t next_r;

  // field of a packed per-module config
  function automatic logic [smsc_pkg::MC_W-1:0] mod_field(
    input logic [31:0] cfg,
    input logic [smsc_pkg::MODW-1:0] m
  );
    mod_field = cfg[m * smsc_pkg::MC_W +: smsc_pkg::MC_W];
  endfunction

  // trigger to module map, MODW bits per trigger
  function automatic logic [smsc_pkg::MODW-1:0] map_trig(
    input logic [31:0] map,
    input int unsigned t
  );
    map_trig = map[t * smsc_pkg::MODW +: smsc_pkg::MODW];
  endfunction

  logic apb_wr;
  logic apb_rd;
  logic [7:0] cmd;
  logic [smsc_pkg::MC_W-1:0] cur_cfg;
  logic [smsc_pkg::MC_W-1:0] nxt_cfg;
  smsc_pkg::smsc_rem_t rem_mode;
  logic [smsc_pkg::NTRIG-1:0] rise;
  logic [smsc_pkg::NTRIG-1:0] sw_trig;
  logic shut_cmd;
  logic trig_found;
  logic [smsc_pkg::MODW-1:0] trig_mod;
  logic [smsc_pkg::NTRIG-1:0] trig_bit;

  // apb decode, first cycle of the access phase only
  assign apb_wr = PSEL && PENABLE && PWRITE && !r.pready;
  assign apb_rd = PSEL && PENABLE && !PWRITE && !r.pready;
  assign cmd = PWDATA[7:0];
  assign cur_cfg = mod_field(r.mod_cfg, r.cur);
  assign nxt_cfg = mod_field(r.mod_cfg, r.nxt);
  assign rem_mode = smsc_pkg::smsc_rem_t'(cur_cfg[smsc_pkg::MC_REMOVE_LSB +: 2]);
  assign shut_cmd = apb_wr && PADDR == smsc_pkg::ADDR_CONTROL && cmd == smsc_pkg::CMD_SHUTDOWN;

  // edge detect on agreeing synchroniser stages
  assign rise = r.trig_q2 & r.trig_q3 & ~r.trig_lvl;
  // register trigger bits, set by a write
  assign sw_trig = (apb_wr && PADDR == smsc_pkg::ADDR_SW_TRIGGER) ? PWDATA[smsc_pkg::NTRIG-1:0] : '0;

  // lowest pending trigger picks the module
  always_comb begin
    trig_found = 1'b0;
    trig_mod = '0;
    trig_bit = '0;
    for (int unsigned t = 0; t < smsc_pkg::NTRIG; t++) begin
      if (!trig_found && r.pend[t]) begin
        trig_found = 1'b1;
        trig_mod = map_trig(r.trig_map, t);
        trig_bit = smsc_pkg::NTRIG'(1) << t;
      end
    end
  end

  // next state of everything
  always_comb begin
    next_r = r;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.intr = 1'b0;
    next_r.f.start = 1'b0;
    // three-stage synchronisers
    next_r.trig_q1 = HARDWARE_TRIGGER_INPUTS;
    next_r.trig_q2 = r.trig_q1;
    next_r.trig_q3 = r.trig_q2;
    next_r.ack_q1 = MODULE_REMOVAL_GRANT;
    next_r.ack_q2 = r.ack_q1;
    next_r.ack_q3 = r.ack_q2;
    if (r.ack_q2 == r.ack_q3) begin
      next_r.ack = r.ack_q3;
    end
    // agreed trigger level, kept while stages differ
    next_r.trig_lvl = (r.trig_q2 & r.trig_q3) | (r.trig_lvl & (r.trig_q2 | r.trig_q3));
    // rising edge once stages agree; never cancelled; ignored when shut
    if (r.st != smsc_pkg::SMSC_S_SHUT) begin
      next_r.pend = next_r.pend | rise; // [RULE23]
      next_r.pend = next_r.pend | sw_trig; // [RULE3]
    end
    // sequencer
    case (r.st)
      // shut down: triggers dropped
      smsc_pkg::SMSC_S_SHUT: begin
        next_r.pend = '0; // [RULE17]
      end
      // idle: wait for a trigger
      smsc_pkg::SMSC_S_IDLE: begin
        if (trig_found) begin // [RULE3]
          next_r.pend = (r.pend & ~trig_bit) | rise | sw_trig; // [RULE23]
          next_r.nxt = trig_mod;
          next_r.hw_done = 1'b0;
          next_r.sw_done = 1'b0;
          // empty socket skips removal
          if (!r.full || rem_mode == smsc_pkg::SMSC_REM_NONE) begin
            next_r.st = CLEARING && r.full ? smsc_pkg::SMSC_S_CLR_REQ : smsc_pkg::SMSC_S_LOAD_REQ;
            next_r.o.isol = 1'b1; // [RULE9]
          end else if (rem_mode == smsc_pkg::SMSC_REM_SW_HW) begin // [RULE4]
            next_r.st = smsc_pkg::SMSC_S_SW_REM;
            next_r.o.swrem = 1'b1;
            next_r.intr = 1'b1; // [RULE7]
          end else begin
            next_r.st = smsc_pkg::SMSC_S_HW_REM;
            next_r.o.remreq = 1'b1; // [RULE5]
          end
        end
      end
      // hardware removal handshake
      smsc_pkg::SMSC_S_HW_REM: begin
        if (r.ack) begin // [RULE5] [RULE6]
          next_r.o.remreq = 1'b0;
          next_r.hw_done = 1'b1;
          if (rem_mode == smsc_pkg::SMSC_REM_HW_SW && !r.sw_done) begin
            next_r.st = smsc_pkg::SMSC_S_SW_REM;
            next_r.o.swrem = 1'b1;
            next_r.intr = 1'b1; // [RULE7]
          end else begin
            next_r.st = CLEARING ? smsc_pkg::SMSC_S_CLR_REQ : smsc_pkg::SMSC_S_LOAD_REQ; // [RULE10]
            next_r.o.isol = 1'b1; // [RULE9]
          end
        end
      end
      // software removal, wait for Proceed
      smsc_pkg::SMSC_S_SW_REM: begin
        if (apb_wr && PADDR == smsc_pkg::ADDR_CONTROL && cmd == smsc_pkg::CMD_PROCEED) begin // [RULE7]
          next_r.o.swrem = 1'b0;
          next_r.sw_done = 1'b1;
          if (rem_mode == smsc_pkg::SMSC_REM_SW_HW && !r.hw_done) begin // [RULE8]
            next_r.st = smsc_pkg::SMSC_S_HW_REM;
            next_r.o.remreq = 1'b1;
          end else begin
            next_r.st = CLEARING ? smsc_pkg::SMSC_S_CLR_REQ : smsc_pkg::SMSC_S_LOAD_REQ;
            next_r.o.isol = 1'b1; // [RULE9]
          end
        end
      end
      // ask for the shared fetch path
      smsc_pkg::SMSC_S_CLR_REQ, smsc_pkg::SMSC_S_LOAD_REQ: begin
        next_r.f.req = 1'b1; // [RULE11]
        next_r.f.clearing = r.st == smsc_pkg::SMSC_S_CLR_REQ; // [RULE10]
        next_r.f.module_id = r.st == smsc_pkg::SMSC_S_CLR_REQ ? r.cur : r.nxt;
        if (r.f.req && FETCH_GRANT) begin // [RULE25]
          next_r.f.start = 1'b1;
          next_r.st = r.st == smsc_pkg::SMSC_S_CLR_REQ ? smsc_pkg::SMSC_S_CLR_XFER : smsc_pkg::SMSC_S_LOAD_XFER;
        end
      end
      // image transfer in flight
      smsc_pkg::SMSC_S_CLR_XFER, smsc_pkg::SMSC_S_LOAD_XFER: begin
        if (FETCH_DONE || FETCH_ERROR) begin
          next_r.f.req = 1'b0; // [RULE25]
          // error leaves the socket empty
          if (FETCH_ERROR) begin
            next_r.err = 1'b1;
            next_r.full = 1'b0;
            next_r.st = ERR_SHUTDOWN ? smsc_pkg::SMSC_S_SHUT : smsc_pkg::SMSC_S_IDLE; // [RULE2]
          end else if (r.st == smsc_pkg::SMSC_S_CLR_XFER) begin
            // cleared, new image next
            next_r.full = 1'b0;
            next_r.st = smsc_pkg::SMSC_S_LOAD_REQ; // [RULE12]
          end else begin
            // new module now occupies the socket
            next_r.full = 1'b1;
            next_r.cur = r.nxt;
            if (nxt_cfg[smsc_pkg::MC_SWUP_BIT]) begin
              next_r.st = smsc_pkg::SMSC_S_SW_UP;
              next_r.o.swup = 1'b1;
              next_r.intr = 1'b1; // [RULE13]
            end else if (nxt_cfg[smsc_pkg::MC_RST_BIT]) begin
              next_r.st = smsc_pkg::SMSC_S_MOD_RST;
              next_r.o.isol = 1'b0; // [RULE15]
              next_r.o.rst = 1'b1;
              next_r.rcnt = r.rst_cycles;
            end else begin
              next_r.st = smsc_pkg::SMSC_S_IDLE; // [RULE16]
              next_r.o.isol = 1'b0; // [RULE9]
            end
          end
        end
      end
      // software bring-up, still isolated
      smsc_pkg::SMSC_S_SW_UP: begin
        if (apb_wr && PADDR == smsc_pkg::ADDR_CONTROL && cmd == smsc_pkg::CMD_PROCEED) begin // [RULE13]
          next_r.o.swup = 1'b0;
          next_r.o.isol = 1'b0; // [RULE15]
          if (cur_cfg[smsc_pkg::MC_RST_BIT]) begin
            next_r.st = smsc_pkg::SMSC_S_MOD_RST;
            next_r.o.rst = 1'b1;
            next_r.rcnt = r.rst_cycles;
          end else begin
            next_r.st = smsc_pkg::SMSC_S_IDLE; // [RULE16]
          end
        end
      end
      // timed module reset
      smsc_pkg::SMSC_S_MOD_RST: begin
        if (r.rcnt <= smsc_pkg::RSTW'(1)) begin // [RULE14]
          next_r.o.rst = 1'b0;
          next_r.st = smsc_pkg::SMSC_S_IDLE; // [RULE16]
        end else begin
          next_r.rcnt = r.rcnt - smsc_pkg::RSTW'(1);
        end
      end
      // unused codes fall back to shut
      default: begin
        next_r.st = smsc_pkg::SMSC_S_SHUT;
      end
    endcase
    // register writes
    if (apb_wr) begin
      case (PADDR)
        // restart and user control need shut
        smsc_pkg::ADDR_CONTROL: begin
          if (r.st == smsc_pkg::SMSC_S_SHUT) begin
            if (cmd == smsc_pkg::CMD_RESTART_NOSTAT) begin
              next_r.st = smsc_pkg::SMSC_S_IDLE; // [RULE19]
              next_r.o = '0;
            end else if (cmd == smsc_pkg::CMD_RESTART_STAT) begin
              next_r.st = smsc_pkg::SMSC_S_IDLE; // [RULE20]
              next_r.o = '0;
              next_r.full = PWDATA[smsc_pkg::CTL_FULL_BIT];
              next_r.cur = PWDATA[smsc_pkg::CTL_MOD_LSB +: smsc_pkg::MODW];
            end else if (cmd == smsc_pkg::CMD_USER_CTRL) begin // [RULE21]
              next_r.o.remreq = PWDATA[smsc_pkg::UC_REMREQ];
              next_r.o.isol = PWDATA[smsc_pkg::UC_ISOL];
              next_r.o.rst = PWDATA[smsc_pkg::UC_RST];
              next_r.o.swrem = PWDATA[smsc_pkg::UC_SWREM];
              next_r.o.swup = PWDATA[smsc_pkg::UC_SWUP];
            end
          end
        end
        // configuration words
        smsc_pkg::ADDR_MOD_CFG: next_r.mod_cfg = PWDATA;
        smsc_pkg::ADDR_TRIG_MAP: next_r.trig_map = PWDATA;
        smsc_pkg::ADDR_RESET_CYCLES: next_r.rst_cycles = PWDATA[smsc_pkg::RSTW-1:0];
        default: begin
        end
      endcase
    end
    // shutdown wins over any sequencer step; only a restart command leaves it
    if (shut_cmd) begin // [RULE18]
      next_r.st = smsc_pkg::SMSC_S_SHUT;
      next_r.f.req = 1'b0;
      next_r.pend = '0;
    end
    // status word: state, module, full, grant, error, pending triggers
    next_r.stat_data = {r.pend, 15'h0000, r.err, r.ack, r.full, 2'(r.cur), r.st}; // [RULE22]
    // apb answer one cycle after access phase starts
    if (PSEL && PENABLE && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = '0;
      // read data, or error for holes
      if (apb_rd) begin
        case (PADDR)
          smsc_pkg::ADDR_STATUS: next_r.prdata = next_r.stat_data;
          smsc_pkg::ADDR_MOD_CFG: next_r.prdata = r.mod_cfg;
          smsc_pkg::ADDR_TRIG_MAP: next_r.prdata = r.trig_map;
          smsc_pkg::ADDR_RESET_CYCLES: next_r.prdata = 32'(r.rst_cycles);
          smsc_pkg::ADDR_CONTROL, smsc_pkg::ADDR_SW_TRIGGER: next_r.prdata = '0;
          default: next_r.pslverr = 1'b1;
        endcase
      end else if (PADDR > smsc_pkg::ADDR_RESET_CYCLES || PADDR[1:0] != 2'h0) begin
        next_r.pslverr = 1'b1;
      end
    end
  end

  // state register, frozen while CE low
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin // [RULE24]
      r <= '0;
      // build option picks the reset state
      r.st <= START_SHUT ? smsc_pkg::SMSC_S_SHUT : smsc_pkg::SMSC_S_IDLE; // [RULE1]
      r.full <= START_FULL;
      r.mod_cfg <= smsc_pkg::MOD_CFG_RST;
      r.trig_map <= smsc_pkg::TRIG_MAP_RST;
      r.rst_cycles <= smsc_pkg::RESET_CYCLES_RST[smsc_pkg::RSTW-1:0];
    end else if (CE) begin
      r <= next_r;
    end
  end

  // outputs from flip-flops; reset level applied at the pin
  assign MODULE_REMOVAL_REQUEST = r.o.remreq;
  assign SOCKET_ISOLATE = r.o.isol;
  assign MODULE_RESET_OUT = r.o.rst ? RESET_LEVEL : !RESET_LEVEL; // [RULE14]
  assign SOFTWARE_REMOVAL_REQUEST = r.o.swrem;
  assign SOFTWARE_BRINGUP_REQUEST = r.o.swup;
  assign SOFTWARE_EVENT = r.intr;
  assign FETCH_REQ = r.f.req;
  assign FETCH_START = r.f.start;
  assign FETCH_CLEARING = r.f.clearing;
  assign FETCH_MODULE = r.f.module_id;
  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign STATUS_STREAM = r.stat_data;

endmodule

`default_nettype wire

// >>> rtl/smsc_pkg.sv
// smsc_pkg: constants, types and register map for the socket manager
// assumes a 32-bit apb master and one 200 MHz clock
package smsc_pkg;

  localparam int unsigned NTRIG = 8;
  localparam int unsigned NMOD = 4;
  localparam int unsigned MODW = 2;
  localparam int unsigned RSTW = 8;

  // register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SW_TRIGGER = 8'h08;
  localparam logic [7:0] ADDR_MOD_CFG = 8'h0c;
  localparam logic [7:0] ADDR_TRIG_MAP = 8'h10;
  localparam logic [7:0] ADDR_RESET_CYCLES = 8'h14;

  // control register command codes in bits 7:0
  localparam logic [7:0] CMD_SHUTDOWN = 8'h01;
  localparam logic [7:0] CMD_RESTART_NOSTAT = 8'h02;
  localparam logic [7:0] CMD_RESTART_STAT = 8'h03;
  localparam logic [7:0] CMD_PROCEED = 8'h04;
  localparam logic [7:0] CMD_USER_CTRL = 8'h05;

  // command argument field positions in the control word
  localparam int unsigned CTL_ARG_LSB = 8;
  localparam int unsigned CTL_FULL_BIT = 16;
  localparam int unsigned CTL_MOD_LSB = 17;
  localparam int unsigned UC_REMREQ = 8;
  localparam int unsigned UC_ISOL = 9;
  localparam int unsigned UC_RST = 10;
  localparam int unsigned UC_SWREM = 11;
  localparam int unsigned UC_SWUP = 12;

  // per-module config field layout, 4 bits per module
  localparam int unsigned MC_W = 4;
  localparam int unsigned MC_REMOVE_LSB = 0;
  localparam int unsigned MC_SWUP_BIT = 2;
  localparam int unsigned MC_RST_BIT = 3;

  // removal modes
  typedef enum logic [1:0] {
    SMSC_REM_NONE = 2'b00,
    SMSC_REM_HW = 2'b01,
    SMSC_REM_HW_SW = 2'b10,
    SMSC_REM_SW_HW = 2'b11
  } smsc_rem_t;

  // sequencer states
  typedef enum logic [3:0] {
    SMSC_S_SHUT = 4'b0000,
    SMSC_S_IDLE = 4'b0001,
    SMSC_S_HW_REM = 4'b0010,
    SMSC_S_SW_REM = 4'b0011,
    SMSC_S_CLR_REQ = 4'b0100,
    SMSC_S_CLR_XFER = 4'b0101,
    SMSC_S_LOAD_REQ = 4'b0110,
    SMSC_S_LOAD_XFER = 4'b0111,
    SMSC_S_SW_UP = 4'b1000,
    SMSC_S_MOD_RST = 4'b1001
  } smsc_state_t;

  localparam logic [31:0] RESET_CYCLES_RST = 32'h00000010;
  localparam logic [31:0] MOD_CFG_RST = 32'h00000000;
  localparam logic [31:0] TRIG_MAP_RST = 32'h0000e4e4;

  // manager outputs toward the socket
  typedef struct packed {
    logic remreq;
    logic isol;
    logic rst;
    logic swrem;
    logic swup;
  } smsc_outs_t;

  // fetch request toward shared fetch path
  typedef struct packed {
    logic req;
    logic start;
    logic clearing;
    logic [MODW-1:0] module_id;
  } smsc_fetch_t;

  // complete state of the manager
  typedef struct packed {
    smsc_state_t st;
    smsc_outs_t o;
    smsc_fetch_t f;
    logic full;
    logic [MODW-1:0] cur;
    logic [MODW-1:0] nxt;
    logic [NTRIG-1:0] pend;
    logic [NTRIG-1:0] trig_q1;
    logic [NTRIG-1:0] trig_q2;
    logic [NTRIG-1:0] trig_q3;
    logic [NTRIG-1:0] trig_lvl;
    logic ack_q1;
    logic ack_q2;
    logic ack_q3;
    logic ack;
    logic hw_done;
    logic sw_done;
    logic [RSTW-1:0] rcnt;
    logic [31:0] mod_cfg;
    logic [31:0] trig_map;
    logic [RSTW-1:0] rst_cycles;
    logic err;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [31:0] stat_data;
    logic intr;
  } smsc_regs_t;

endpackage

// >>> tb/smsc_manager_assertions.sv
// smsc_manager_chk: concurrent checks on the socket manager top ports
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module smsc_manager_chk #(
  parameter bit RESET_LEVEL = 1'b1
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic MODULE_REMOVAL_GRANT,
  input wire logic MODULE_REMOVAL_REQUEST,
  input wire logic SOCKET_ISOLATE,
  input wire logic MODULE_RESET_OUT,
  input wire logic SOFTWARE_REMOVAL_REQUEST,
  input wire logic SOFTWARE_BRINGUP_REQUEST,
  input wire logic SOFTWARE_EVENT,
  input wire logic FETCH_REQ,
  input wire logic FETCH_GRANT,
  input wire logic FETCH_START,
  input wire logic FETCH_DONE,
  input wire logic FETCH_ERROR,
  input wire logic [31:0] STATUS_STREAM
);
  logic shut;
  logic rst_on;
  logic [7:0] rcnt;
  // shut-down seen on the stream, one cycle late
  assign shut = STATUS_STREAM[3:0] == smsc_pkg::SMSC_S_SHUT;
  assign rst_on = MODULE_RESET_OUT == RESET_LEVEL;
  // length of the running module reset pulse
  always_ff @(posedge CORE_CLK) begin
    if (RST || !rst_on) begin
      rcnt <= 8'h00;
    end else if (rcnt != 8'hff) begin
      rcnt <= rcnt + 8'h01;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_apb_ready: assert property (PREADY |-> $past(PSEL && PENABLE) ##1 !PREADY)
    else $error("ready without access or longer than one cycle");
  chk_rem_hold: assert property ($fell(MODULE_REMOVAL_REQUEST) && !shut |-> MODULE_REMOVAL_GRANT)
    else $error("removal request dropped without grant");
  chk_fetch_start: assert property (FETCH_START |-> $past(FETCH_REQ && FETCH_GRANT))
    else $error("fetch started without granted request");
  chk_fetch_hold: assert property ($fell(FETCH_REQ) && !shut |-> $past(FETCH_DONE || FETCH_ERROR))
    else $error("fetch request dropped before transfer end");
  chk_isol_fetch: assert property (FETCH_REQ |-> SOCKET_ISOLATE)
    else $error("fetch path used while socket not isolated");
  chk_isol_reset: assert property ($rose(rst_on) && !shut |-> !SOCKET_ISOLATE)
    else $error("isolation still held in module reset");
  chk_rst_len: assert property ($fell(rst_on) && !shut |-> rcnt == smsc_pkg::RESET_CYCLES_RST[7:0])
    else $error("module reset pulse has wrong length");
  chk_sw_event: assert property ($rose(SOFTWARE_REMOVAL_REQUEST || SOFTWARE_BRINGUP_REQUEST) && !shut
    |-> SOFTWARE_EVENT || $past(SOFTWARE_EVENT))
    else $error("software request without event pulse");
  chk_no_load_shut: assert property ($rose(FETCH_REQ) |-> !shut)
    else $error("load started while shut down");
  chk_grant_stat: assert property ($rose(MODULE_REMOVAL_GRANT) |-> ##[1:10] STATUS_STREAM[7])
    else $error("grant not shown on status stream");
endmodule

bind smsc_manager smsc_manager_chk #(.RESET_LEVEL(RESET_LEVEL)) i_chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .MODULE_REMOVAL_GRANT(MODULE_REMOVAL_GRANT),
  .MODULE_REMOVAL_REQUEST(MODULE_REMOVAL_REQUEST), .SOCKET_ISOLATE(SOCKET_ISOLATE),
  .MODULE_RESET_OUT(MODULE_RESET_OUT), .SOFTWARE_REMOVAL_REQUEST(SOFTWARE_REMOVAL_REQUEST),
  .SOFTWARE_BRINGUP_REQUEST(SOFTWARE_BRINGUP_REQUEST), .SOFTWARE_EVENT(SOFTWARE_EVENT),
  .FETCH_REQ(FETCH_REQ), .FETCH_GRANT(FETCH_GRANT), .FETCH_START(FETCH_START), .FETCH_DONE(FETCH_DONE),
  .FETCH_ERROR(FETCH_ERROR), .STATUS_STREAM(STATUS_STREAM));

`default_nettype wire

// >>> tb/smsc_socket_model.sv
// smsc_socket_model: reconfigurable module and shared fetch path
// assumes the manager's outputs change just after rising edges
`timescale 1ns/10ps
`default_nettype none

module smsc_socket_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic sw_only,
  input wire logic err_inj,
  input wire logic rem_req,
  input wire logic isol,
  output logic grant,
  input wire logic f_req,
  output logic f_grant,
  output logic f_done,
  output logic f_err
);
  int n;
  int k;
  logic held;
  // grant removal after a delay, keep it until isolated
  always @(posedge clk) begin
    if (rst || (held && isol)) begin
      held <= 1'b0;
      n <= 0;
    end else if (rem_req && !held) begin
      n <= n + 1;
      held <= n == (slow ? 12 : 2);
    end
  end
  assign grant = held || sw_only;
  // one requester at a time, grant kept until the transfer ends
  always @(posedge clk) begin
    f_done <= 1'b0;
    f_err <= 1'b0;
    if (rst || !f_req) begin
      k <= 0;
      f_grant <= 1'b0;
    end else begin
      k <= k + 1;
      if (k == (slow ? 9 : 1)) f_grant <= 1'b1;
      if (k == 20) begin
        f_done <= !err_inj;
        f_err <= err_inj;
      end
    end
  end
endmodule

`default_nettype wire

// >>> tb/smsc_manager_tb.sv
// smsc_manager_tb: self-checking bench for one socket manager
// assumes default build options and the socket model on the far side
`timescale 1ns/10ps
`default_nettype none

module smsc_manager_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, grant, rem, isol, rst_o, swrem, swup;
  logic freq, fgnt, fstart, fdone, ferr, slow, sw_only, err_inj;
  logic [7:0] paddr, trig;
  logic [31:0] pwdata, prdata;
  logic [1:0] fmod;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  logic [1:0] mod_q[$];
  int n_fail = 0;
  int num_checks = 0;
  int seed = 86654;
  int cyc = 0;
  int i;
  int r;

  always #2.5 clk = !clk;

  smsc_manager i_dut (.CORE_CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HARDWARE_TRIGGER_INPUTS(trig), .MODULE_REMOVAL_GRANT(grant), .MODULE_REMOVAL_REQUEST(rem),
    .SOCKET_ISOLATE(isol), .MODULE_RESET_OUT(rst_o), .SOFTWARE_REMOVAL_REQUEST(swrem),
    .SOFTWARE_BRINGUP_REQUEST(swup), .SOFTWARE_EVENT(), .FETCH_REQ(freq), .FETCH_GRANT(fgnt),
    .FETCH_START(fstart), .FETCH_CLEARING(), .FETCH_MODULE(fmod), .FETCH_DONE(fdone), .FETCH_ERROR(ferr),
    .STATUS_STREAM());

  smsc_socket_model i_model (.clk(clk), .rst(rst), .slow(slow), .sw_only(sw_only), .err_inj(err_inj),
    .rem_req(rem), .isol(isol), .grant(grant), .f_req(freq), .f_grant(fgnt), .f_done(fdone), .f_err(ferr));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // oldest noted result against each answer, plus the run limit
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) chk(33'h1, 33'h0);
      else chk({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
    end
    if (fstart === 1'b1) begin
      if (mod_q.size() == 0) chk(33'h1, 33'h0);
      else chk({31'h0, fmod}, {31'h0, mod_q.pop_front()});
    end
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  // one apb transfer, expectation noted first
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] m,
                     input logic [32:0] e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (int t = 0; t < 50 && pready !== 1'b1; t++) @(posedge clk);
    if (pready !== 1'b1) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h100000000, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b1, m}, {1'b0, e});
  endtask

  // answer software requests until the load has settled
  task automatic serve();
    for (int n = 0; n < 400; n++) begin
      if (swrem === 1'b1 || swup === 1'b1) begin
        repeat (8) @(posedge clk);
        chk({32'h0, swrem || swup}, 33'h1);
        chk({32'h0, isol}, {32'h0, swup});
        wr(smsc_pkg::ADDR_CONTROL, {24'h0, smsc_pkg::CMD_PROCEED});
      end else @(posedge clk);
    end
  endtask

  // trigger b by pin edge or register, then service the load
  task automatic load(input int b, input logic hw, input logic e);
    int s;
    mod_q.push_back(b[1:0]);
    s = $random(seed);
    slow <= s[0];
    err_inj <= e;
    if (hw) begin
      trig[b] <= 1'b1;
      repeat (6) @(posedge clk);
      trig[b] <= 1'b0;
      @(posedge clk);
    end else wr(smsc_pkg::ADDR_SW_TRIGGER, 32'h1 << b);
    serve();
    $display("load of module %0d done", b[1:0]);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, slow, sw_only, err_inj} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    trig = 8'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // reset state, refused place, register reset values
    rd(smsc_pkg::ADDR_STATUS, 32'hffffffff, 32'h00000001);
    apb(1'b0, 8'hfc, 32'h0, 33'h100000000, 33'h100000000);
    rd(smsc_pkg::ADDR_TRIG_MAP, 32'hffffffff, smsc_pkg::TRIG_MAP_RST);
    rd(smsc_pkg::ADDR_RESET_CYCLES, 32'hffffffff, smsc_pkg::RESET_CYCLES_RST);
    // modules: hw, sw then hw with bring-up and reset, hw then sw, none with reset
    wr(smsc_pkg::ADDR_MOD_CFG, 32'h000082f1);
    rd(smsc_pkg::ADDR_MOD_CFG, 32'hffffffff, 32'h000082f1);
    load(1, 1'b1, 1'b0);
    rd(smsc_pkg::ADDR_STATUS, 32'h7f, 32'h51);
    load(2, 1'b0, 1'b0);
    rd(smsc_pkg::ADDR_STATUS, 32'h7f, 32'h61);
    load(4, 1'b1, 1'b0);
    rd(smsc_pkg::ADDR_STATUS, 32'h7f, 32'h41);
    load(3, 1'b0, 1'b1);
    rd(smsc_pkg::ADDR_STATUS, 32'h10f, 32'h100);
    // triggers are dropped while shut down
    err_inj <= 1'b0;
    trig[7] <= 1'b1;
    repeat (40) @(posedge clk);
    trig[7] <= 1'b0;
    chk({32'h0, freq}, 33'h0);
    // direct output control, one output at a time then none
    for (i = 0; i < 6; i++) begin
      wr(smsc_pkg::ADDR_CONTROL, {19'h0, 5'h1 << i, smsc_pkg::CMD_USER_CTRL});
      @(posedge clk);
      chk({28'h0, swup, swrem, rst_o, isol, rem}, {28'h0, 5'h1 << i});
    end
    $display("shut-down control done");
    wr(smsc_pkg::ADDR_CONTROL, {13'h0, 2'h3, 1'b1, 8'h0, smsc_pkg::CMD_RESTART_STAT});
    rd(smsc_pkg::ADDR_STATUS, 32'h7f, 32'h71);
    wr(smsc_pkg::ADDR_CONTROL, {24'h0, smsc_pkg::CMD_SHUTDOWN});
    rd(smsc_pkg::ADDR_STATUS, 32'h7f, 32'h70);
    wr(smsc_pkg::ADDR_CONTROL, {24'h0, smsc_pkg::CMD_RESTART_NOSTAT});
    rd(smsc_pkg::ADDR_STATUS, 32'h7f, 32'h71);
    // random triggers, pin or register, grant sometimes tied high
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      sw_only <= r[4];
      load(r[2:0], r[3], 1'b0);
      rd(smsc_pkg::ADDR_STATUS, 32'h7f, {26'h1, r[1:0], 4'h1});
    end
    chk(33'(exp_q.size() + mod_q.size()), 33'h0);
    print_verdict();
  end
endmodule

`default_nettype wire
